/* core/servo_pkg.sv */
/*
  Shared constants and types for the axis control-mode sequencer: register
  offsets, control field positions, minor error codes, reset values, mode enum
  and the amplifier-side carriers.
  Assumes a 50 MHz pclk and a 32-bit APB with byte addressing.
*/
package servo_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int OP_CYCLE_NS = 1000; // controller operation cycle
  localparam int OP_CYCLE_CYC = (OP_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SPD_CMD = 8'h04;
  localparam logic [7:0] OFF_TQ_CMD = 8'h08;
  localparam logic [7:0] OFF_SPD_LIM = 8'h0C;
  localparam logic [7:0] OFF_ACC_TIME = 8'h10;
  localparam logic [7:0] OFF_DEC_TIME = 8'h14;
  localparam logic [7:0] OFF_TQ_LIM_MAX = 8'h18;
  localparam logic [7:0] OFF_TQ_LIM_REQ = 8'h1C;
  localparam logic [7:0] OFF_STROKE_HI = 8'h20;
  localparam logic [7:0] OFF_STROKE_LO = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_CMD_SPEED = 8'h2C;
  localparam logic [7:0] OFF_FEED_POS = 8'h30;
  localparam logic [7:0] OFF_REAL_POS = 8'h34;
  localparam logic [7:0] OFF_STATUS3 = 8'h38;
  localparam logic [7:0] OFF_TQ_LIM = 8'h3C;

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_W = 11;
  localparam int CTRL_REQ = 2;       // mode switching request level
  localparam int CTRL_AMP_OK = 3;    // amplifier supports continuous torque
  localparam int CTRL_ZCHK_DIS = 4;  // zero-speed check disabled
  localparam int CTRL_TQ_SEL = 5;    // torque initial selector
  localparam int CTRL_SPD_SEL = 6;   // speed initial selector, 2 bits
  localparam int CTRL_STROKE_EN = 8; // software stroke limit enable
  localparam int CTRL_SPD_CHG = 9;   // write-one pulse, speed change request
  localparam int CTRL_TQ_CHG = 10;   // write-one pulse, torque limit change
  localparam int ST3_CTQ_BIT = 14;
  localparam int ST2_ZERO_BIT = 3;

  // ----------------------------------------------------------------------
  // minor error codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] ERR_MODE = 16'h009B;   // 155
  localparam logic [15:0] ERR_STROKE = 16'h00CF; // 207
  localparam logic [15:0] ERR_SPD_LIM = 16'h013B;// 315
  localparam logic [15:0] ERR_AMP = 16'h013E;    // 318
  localparam logic [15:0] ERR_TQ_LIM = 16'h013F; // 319
  localparam logic [31:0] SPD_LIM_RST = 32'h0000_1000;
  localparam logic [15:0] TIME_RST = 16'h0010;
  localparam logic [15:0] TQ_LIM_RST = 16'h012C;
  localparam logic [31:0] STROKE_HI_RST = 32'h7FFF_FFFF;
  localparam logic [31:0] STROKE_LO_RST = 32'h8000_0000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {MODE_POS, MODE_SPD, MODE_CTQ} mode_e;

  typedef struct packed {
    logic signed [15:0] current;
    logic signed [31:0] speed;
    logic [15:0] status2;
  } amp_fb_s;

  typedef struct packed {
    logic signed [31:0] speed;
    logic signed [15:0] torque;
    logic [15:0] torque_limit;
    logic ctq_mode;
    logic decel_stop;
    logic stop_now;
  } amp_cmd_s;

endpackage : servo_pkg

/* core/speed_ramp.sv */
/*
  Trapezoidal ramp step: one operation-cycle step of the commanded speed toward
  its target. Acceleration and deceleration times are counted in operation
  cycles to travel the whole speed limit.
  Assumes the caller updates cur only on operation-cycle ticks.
*/
module speed_ramp (
  // ramp inputs
  input wire logic signed [31:0] cur,
  input wire logic signed [31:0] tgt,
  input wire logic [31:0] lim,
  input wire logic [15:0] acc_time,
  input wire logic [15:0] dec_time,
  // next speed
  output logic signed [31:0] nxt
);

  logic signed [32:0] diff;
  logic [31:0] cur_mag;
  logic [31:0] tgt_mag;
  logic [31:0] step;
  logic decel;

  // moving toward zero or crossing it counts as deceleration
  always_comb begin
    diff = 33'(tgt) - 33'(cur);
    cur_mag = cur[31] ? 32'(-cur) : 32'(cur);
    tgt_mag = tgt[31] ? 32'(-tgt) : 32'(tgt);
    decel = (cur[31] != tgt[31] && cur != 32'h0000_0000) || tgt_mag < cur_mag;
    // a zero time steps by the whole speed limit at once; a step below one is raised to one
    if (decel) begin
      step = (dec_time == 16'h0000) ? lim : lim / 32'(dec_time);
    end else begin
      step = (acc_time == 16'h0000) ? lim : lim / 32'(acc_time);
    end
    if (step == 32'h0000_0000) begin
      step = 32'h0000_0001;
    end
    // signed compare: an unsigned step would make a negative diff look huge
    if (diff > $signed({1'b0, step})) begin
      nxt = 32'(33'(cur) + 33'(step));
    end else if (diff < -$signed({1'b0, step})) begin
      nxt = 32'(33'(cur) - 33'(step));
    end else begin
      nxt = tgt;
    end
  end

endmodule : speed_ramp

/* core/axis_mode_ctrl.sv */
/*
  Per-axis control-mode sequencer with speed control: switches between
  position, speed and continuous-torque modes, ramps the speed command,
  clamps limits, handles torque limit changes and stroke fallback.
  Assumes APB from the host, synchronous amplifier feedback and a
  positioning sequencer elsewhere that reports busy and done events.
*/
// The address map and the APB slave port were decided locally.
// Functional notes
// - From torque-via-position, only position mode allowed
// - From torque-via-speed, only speed mode allowed
// - Mode switch never asserts positioning done signals
// - Start-accepted held high in continuous torque
// - Incompatible amplifier: error 318, stop axis
// - Initial torque follows torque selector
// - Initial speed follows speed selector
// - Leaving torque for speed discards torque command
// - Speed mode drives signed speed command
// - Trapezoidal ramp scaled to speed limit
// - Ramp times sampled on request rising edge
// - Over-limit speed: error 315, run at limit
// - Commanded speed readable in monitor register
// - Speed change requests ignored in speed mode
// - Torque limit change checked, else error 319
// - Feed and real position update every operation cycle
// - Stroke limit overrun: error 207, position mode
// - Torque to position needs zero speed unless disabled
// - Status word3 bit 14 shows continuous torque
module axis_mode_ctrl #(
  parameter int OPCYC = servo_pkg::OP_CYCLE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // amplifier
  input wire servo_pkg::amp_fb_s amp_fb,
  output servo_pkg::amp_cmd_s amp_cmd,
  // positioning sequencer
  input wire logic pos_busy,
  input wire logic pos_start_done_src,
  input wire logic pos_done_src,
  // axis status
  output logic axis_start_accepted,
  output logic positioning_start_done,
  output logic positioning_done,
  output logic [15:0] servo_status_word3
);
  import servo_pkg::*;

  typedef struct packed {
    mode_e mode;
    mode_e ctq_from;
    logic req_d;
    logic [CTRL_W-1:0] ctrl;
    logic signed [31:0] spd_cmd;
    logic signed [15:0] tq_cmd;
    logic [31:0] spd_lim;
    logic [15:0] acc;
    logic [15:0] dec;
    logic [15:0] acc_s;
    logic [15:0] dec_s;
    logic [15:0] tq_lim_max;
    logic [15:0] tq_lim_req;
    logic [15:0] tq_lim;
    logic signed [31:0] stroke_hi;
    logic signed [31:0] stroke_lo;
    logic signed [31:0] feed;
    logic signed [31:0] real_pos;
    logic signed [31:0] cmd_spd;
    logic signed [15:0] cmd_tq;
    logic err_flag;
    logic [15:0] err_code;
    logic spd_chg_seen;
    logic decel;
    logic stop_now;
    logic [15:0] div;
    logic tick;
    logic [31:0] prdata;
    logic slverr;
    logic psd;
    logic pd;
    logic asa;
  } st_s;

  st_s st_r;
  st_s st_nxt;
  logic signed [31:0] ramp_nxt;
  logic signed [31:0] clamped;
  logic over_lim;
  logic [31:0] cmd_mag;
  logic [31:0] fb_mag;
  logic [31:0] spd_cmd_mag;
  logic req_edge;
  logic wr;
  logic rd_setup;
  mode_e tgt;

  // ----------------------------------------------------------------------
  // speed ramp
  // ----------------------------------------------------------------------
  speed_ramp u_ramp (
    .cur(st_r.cmd_spd),
    .tgt(clamped),
    .lim(st_r.spd_lim),
    .acc_time(st_r.acc_s),
    .dec_time(st_r.dec_s),
    .nxt(ramp_nxt)
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    wr = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    req_edge = st_r.ctrl[CTRL_REQ] & ~st_r.req_d;
    tgt = mode_e'(st_r.ctrl[1:0]);
    spd_cmd_mag = st_r.spd_cmd[31] ? 32'(-st_r.spd_cmd) : 32'(st_r.spd_cmd);
    over_lim = spd_cmd_mag > st_r.spd_lim;
    // clamp keeps the sign so reverse runs at the negative limit
    clamped = over_lim ? (st_r.spd_cmd[31] ? -st_r.spd_lim : st_r.spd_lim) : st_r.spd_cmd;
    cmd_mag = st_r.cmd_spd[31] ? 32'(-st_r.cmd_spd) : 32'(st_r.cmd_spd);
    fb_mag = amp_fb.speed[31] ? 32'(-amp_fb.speed) : 32'(amp_fb.speed);
    st_nxt.req_d = st_r.ctrl[CTRL_REQ];
    st_nxt.decel = 1'b0;
    st_nxt.stop_now = 1'b0;

    // operation-cycle divider
    if (st_r.div == 16'(OPCYC - 1)) begin
      st_nxt.div = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.div = st_r.div + 16'h0001;
      st_nxt.tick = 1'b0;
    end

    // apb read data is captured in setup so the access phase needs no wait
    if (rd_setup) begin
      st_nxt.slverr = 1'b0;
      st_nxt.prdata = 32'h0000_0000;
      if (paddr == OFF_CTRL) begin
        st_nxt.prdata = 32'(st_r.ctrl[8:0]);
      end else if (paddr == OFF_SPD_CMD) begin
        st_nxt.prdata = st_r.spd_cmd;
      end else if (paddr == OFF_TQ_CMD) begin
        st_nxt.prdata = 32'(st_r.tq_cmd);
      end else if (paddr == OFF_SPD_LIM) begin
        st_nxt.prdata = st_r.spd_lim;
      end else if (paddr == OFF_ACC_TIME) begin
        st_nxt.prdata = 32'(st_r.acc);
      end else if (paddr == OFF_DEC_TIME) begin
        st_nxt.prdata = 32'(st_r.dec);
      end else if (paddr == OFF_TQ_LIM_MAX) begin
        st_nxt.prdata = 32'(st_r.tq_lim_max);
      end else if (paddr == OFF_TQ_LIM_REQ) begin
        st_nxt.prdata = 32'(st_r.tq_lim_req);
      end else if (paddr == OFF_STROKE_HI) begin
        st_nxt.prdata = st_r.stroke_hi;
      end else if (paddr == OFF_STROKE_LO) begin
        st_nxt.prdata = st_r.stroke_lo;
      end else if (paddr == OFF_STATUS) begin
        st_nxt.prdata = {st_r.err_code, 8'h00, st_r.spd_chg_seen, st_r.asa, st_r.err_flag, 1'b0,
                         st_r.ctq_from, st_r.mode};
      end else if (paddr == OFF_CMD_SPEED) begin
        st_nxt.prdata = st_r.cmd_spd;
      end else if (paddr == OFF_FEED_POS) begin
        st_nxt.prdata = st_r.feed;
      end else if (paddr == OFF_REAL_POS) begin
        st_nxt.prdata = st_r.real_pos;
      end else if (paddr == OFF_STATUS3) begin
        st_nxt.prdata = 32'(servo_status_word3);
      end else if (paddr == OFF_TQ_LIM) begin
        st_nxt.prdata = 32'(st_r.tq_lim);
      end else begin
        st_nxt.slverr = 1'b1;
      end
    end else if (psel & ~penable & pwrite) begin
      st_nxt.slverr = (paddr > OFF_TQ_LIM) || (paddr[1:0] != 2'b00);
    end

    // apb writes; any write to the status word clears the minor error
    if (wr) begin
      if (paddr == OFF_CTRL) begin
        st_nxt.ctrl = {2'b00, pwdata[8:0]};
        if (pwdata[CTRL_SPD_CHG]) begin
          st_nxt.spd_chg_seen = 1'b1; // no operation, only noted
        end
        if (pwdata[CTRL_TQ_CHG]) begin
          if (st_r.tq_lim_req <= st_r.tq_lim_max) begin
            st_nxt.tq_lim = st_r.tq_lim_req;
          end else begin
            st_nxt.err_flag = 1'b1;
            st_nxt.err_code = ERR_TQ_LIM;
          end
        end
      end else if (paddr == OFF_SPD_CMD) begin
        st_nxt.spd_cmd = pwdata;
      end else if (paddr == OFF_TQ_CMD) begin
        st_nxt.tq_cmd = pwdata[15:0];
      end else if (paddr == OFF_SPD_LIM) begin
        st_nxt.spd_lim = pwdata;
      end else if (paddr == OFF_ACC_TIME) begin
        st_nxt.acc = pwdata[15:0];
      end else if (paddr == OFF_DEC_TIME) begin
        st_nxt.dec = pwdata[15:0];
      end else if (paddr == OFF_TQ_LIM_MAX) begin
        st_nxt.tq_lim_max = pwdata[15:0];
      end else if (paddr == OFF_TQ_LIM_REQ) begin
        st_nxt.tq_lim_req = pwdata[15:0];
      end else if (paddr == OFF_STROKE_HI) begin
        st_nxt.stroke_hi = pwdata;
      end else if (paddr == OFF_STROKE_LO) begin
        st_nxt.stroke_lo = pwdata;
      end else if (paddr == OFF_STATUS) begin
        st_nxt.err_flag = 1'b0;
        st_nxt.spd_chg_seen = 1'b0;
      end
    end

    // operation cycle: positions always advance, speed mode ramps
    if (st_r.tick) begin
      st_nxt.feed = st_r.feed + st_r.cmd_spd;
      st_nxt.real_pos = st_r.real_pos + amp_fb.speed;
      case (st_r.mode)
        MODE_SPD: begin
          st_nxt.cmd_spd = ramp_nxt;
          if (over_lim) begin
            st_nxt.err_flag = 1'b1;
            st_nxt.err_code = ERR_SPD_LIM;
          end
          if (st_r.ctrl[CTRL_STROKE_EN] && (st_r.feed > st_r.stroke_hi || st_r.feed < st_r.stroke_lo)) begin
            st_nxt.err_flag = 1'b1;
            st_nxt.err_code = ERR_STROKE;
            st_nxt.mode = MODE_POS;
            st_nxt.cmd_spd = 32'h0000_0000;
          end
        end
        MODE_CTQ: begin
          st_nxt.cmd_spd = clamped;
          st_nxt.cmd_tq = st_r.tq_cmd;
        end
        default: begin
          st_nxt.cmd_spd = 32'h0000_0000;
        end
      endcase
    end

    // mode switch, one evaluation per request edge; errors win over tick
    if (req_edge) begin
      st_nxt.acc_s = st_r.acc;
      st_nxt.dec_s = st_r.dec;
      case (st_r.mode)
        MODE_CTQ: begin
          if (tgt != st_r.ctq_from) begin
            st_nxt.err_flag = 1'b1;
            st_nxt.err_code = ERR_MODE;
          end else if (st_r.ctq_from == MODE_POS) begin
            if (amp_fb.status2[ST2_ZERO_BIT] || st_r.ctrl[CTRL_ZCHK_DIS]) begin
              st_nxt.mode = MODE_POS;
              st_nxt.cmd_tq = 16'h0000;
            end
          end else begin
            st_nxt.mode = MODE_SPD;
            st_nxt.cmd_tq = 16'h0000;
          end
        end
        default: begin
          if (tgt == MODE_CTQ) begin
            if (!st_r.ctrl[CTRL_AMP_OK]) begin
              st_nxt.err_flag = 1'b1;
              st_nxt.err_code = ERR_AMP;
              if (st_r.mode == MODE_SPD) begin
                st_nxt.mode = MODE_POS;
                st_nxt.stop_now = 1'b1;
                st_nxt.cmd_spd = 32'h0000_0000;
              end else begin
                st_nxt.decel = pos_busy;
              end
            end else if (!(st_r.mode == MODE_POS && pos_busy)) begin
              st_nxt.mode = MODE_CTQ;
              st_nxt.ctq_from = st_r.mode;
              st_nxt.cmd_tq = st_r.ctrl[CTRL_TQ_SEL] ? amp_fb.current : st_r.tq_cmd;
              case (st_r.ctrl[CTRL_SPD_SEL +: 2])
                2'b00: st_nxt.cmd_spd = st_r.cmd_spd;
                2'b01: st_nxt.cmd_spd = amp_fb.speed;
                default: st_nxt.cmd_spd = (fb_mag < cmd_mag) ? amp_fb.speed : st_r.cmd_spd;
              endcase
            end
          end else if (tgt == MODE_POS || tgt == MODE_SPD) begin
            st_nxt.mode = tgt;
          end
        end
      endcase
    end

    // positioning events pass only from the positioning sequencer
    st_nxt.psd = pos_start_done_src;
    st_nxt.pd = pos_done_src;
    st_nxt.asa = (st_nxt.mode == MODE_CTQ) | pos_busy;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.spd_lim <= SPD_LIM_RST;
      st_r.acc <= TIME_RST;
      st_r.dec <= TIME_RST;
      st_r.acc_s <= TIME_RST;
      st_r.dec_s <= TIME_RST;
      st_r.tq_lim_max <= TQ_LIM_RST;
      st_r.tq_lim <= TQ_LIM_RST;
      st_r.stroke_hi <= STROKE_HI_RST;
      st_r.stroke_lo <= STROKE_LO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign prdata = st_r.prdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & st_r.slverr;
  assign amp_cmd = '{speed: st_r.cmd_spd, torque: st_r.cmd_tq, torque_limit: st_r.tq_lim,
                     ctq_mode: st_r.mode == MODE_CTQ, decel_stop: st_r.decel, stop_now: st_r.stop_now};
  assign axis_start_accepted = st_r.asa;
  assign positioning_start_done = st_r.psd;
  assign positioning_done = st_r.pd;
  assign servo_status_word3 = 16'(st_r.mode == MODE_CTQ) << ST3_CTQ_BIT;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ctq_pos_only: assert property (req_edge && st_r.mode == MODE_CTQ && st_r.ctq_from == MODE_POS
    && st_r.ctrl[1:0] != 2'b00 |=> st_r.mode == MODE_CTQ && st_r.err_code == ERR_MODE)
    else $error("bad mode left torque-from-position");
  a_ctq_spd_only: assert property (req_edge && st_r.mode == MODE_CTQ && st_r.ctq_from == MODE_SPD
    && st_r.ctrl[1:0] != 2'b01 |=> st_r.mode == MODE_CTQ && st_r.err_code == ERR_MODE)
    else $error("bad mode left torque-from-speed");
  a_switch_no_done: assert property (req_edge && !pos_done_src && !pos_start_done_src
    |=> !positioning_done && !positioning_start_done)
    else $error("mode switch raised positioning done");
  a_ctq_accepted: assert property (amp_cmd.ctq_mode |-> axis_start_accepted)
    else $error("start accepted low in torque mode");
  a_amp_reject: assert property (req_edge && st_r.mode != MODE_CTQ && st_r.ctrl[1:0] == 2'b10
    && !st_r.ctrl[CTRL_AMP_OK] |=> st_r.err_code == ERR_AMP && st_r.mode != MODE_CTQ)
    else $error("incompatible amplifier not refused");
  a_torque_init: assert property (req_edge && st_r.mode == MODE_SPD && st_r.ctrl[1:0] == 2'b10
    && st_r.ctrl[CTRL_AMP_OK] && !st_r.ctrl[CTRL_TQ_SEL] |=> amp_cmd.torque == $past(st_r.tq_cmd))
    else $error("initial torque not command value");
  a_acc_sample: assert property (req_edge |=> st_r.acc_s == $past(st_r.acc) && st_r.dec_s == $past(st_r.dec))
    else $error("ramp times not sampled on request");
  a_spd_limit: assert property (st_r.tick && st_r.mode == MODE_SPD && over_lim && !req_edge
    |=> st_r.err_flag && (st_r.err_code == ERR_SPD_LIM || st_r.err_code == ERR_STROKE))
    else $error("speed over limit not flagged");
  a_stroke_fall: assert property (st_r.tick && st_r.mode == MODE_SPD && !req_edge && st_r.ctrl[CTRL_STROKE_EN]
    && st_r.feed > st_r.stroke_hi |=> st_r.mode == MODE_POS && st_r.cmd_spd == 32'h0000_0000)
    else $error("stroke overrun kept speed mode");
  a_status3_ctq: assert property (req_edge && st_r.mode != MODE_CTQ && st_r.ctrl[1:0] == 2'b10
    && st_r.ctrl[CTRL_AMP_OK] && !pos_busy |=> servo_status_word3[ST3_CTQ_BIT])
    else $error("status word3 bit 14 not set");

endmodule : axis_mode_ctrl

/* test/amp_model.sv */
/*
  Behavioural servo amplifier facing the axis sequencer.
  Assumes the sequencer's pclk and presetn; feedback is registered one cycle.
*/
module amp_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lag select from the bench
  input wire logic slow,
  // amplifier link
  input wire servo_pkg::amp_cmd_s amp_cmd,
  output servo_pkg::amp_fb_s amp_fb
);
  timeunit 1ns;
  timeprecision 1ps;
  import servo_pkg::*;
  logic signed [31:0] fb_spd;
  // a slow motor trails the command, so feedback and command differ at switching
  assign fb_spd = amp_cmd.speed - (slow ? 32'sh10 : 32'sh0);
  // current mirrors the previous cycle's torque plus an offset, so it differs from a steady command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_fb <= '0;
    end else begin
      amp_fb.speed <= fb_spd;
      amp_fb.current <= amp_cmd.torque + 16'sh3;
      amp_fb.status2 <= {12'h0, fb_spd == 32'sh0, 3'h0};
    end
  end
endmodule : amp_model

/* test/servo_axis_mode_switch_speed_ctrl_bench.sv */
/*
  Self-checking bench for the axis mode sequencer with an amplifier model.
  Assumes zero-wait APB and an operation cycle shortened to 4 clocks.
*/
module servo_axis_mode_switch_speed_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import servo_pkg::*;
  localparam int OPC = 4;
  logic pclk, presetn, psel, penable, pwrite, slow, perr, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, p1;
  logic pready, pslverr, asa, psd, pd;
  logic [15:0] st3;
  amp_fb_s amp_fb;
  amp_cmd_s amp_cmd;
  int fails = 0;
  int num_checks = 0;
  logic [31:0] init_spd, init_tq;
  logic ctq_d = 1'b0, stop_seen = 1'b0, decel_seen = 1'b0;
  logic [7:0] ra[8] = '{OFF_SPD_LIM, OFF_ACC_TIME, OFF_DEC_TIME, OFF_TQ_LIM_MAX,
                        OFF_STROKE_HI, OFF_STROKE_LO, OFF_TQ_LIM, OFF_STATUS};
  logic [31:0] rv[8] = '{SPD_LIM_RST, 32'(TIME_RST), 32'(TIME_RST), 32'(TQ_LIM_RST),
                         STROKE_HI_RST, STROKE_LO_RST, 32'(TQ_LIM_RST), 32'h0};
  axis_mode_ctrl #(.OPCYC(OPC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .amp_fb(amp_fb), .amp_cmd(amp_cmd), .pos_busy(busy), .pos_start_done_src(1'b0), .pos_done_src(1'b0),
    .axis_start_accepted(asa), .positioning_start_done(psd), .positioning_done(pd), .servo_status_word3(st3));
  amp_model amp_u (.pclk(pclk), .presetn(presetn), .slow(slow), .amp_cmd(amp_cmd), .amp_fb(amp_fb));
  // first command after entering torque mode; a later tick overwrites it, so catch it here
  always @(posedge pclk) begin
    ctq_d <= amp_cmd.ctq_mode;
    if (amp_cmd.ctq_mode && !ctq_d) begin
      init_spd <= amp_cmd.speed;
      init_tq <= 32'(amp_cmd.torque);
    end
    if (amp_cmd.stop_now) stop_seen <= 1'b1;
    if (amp_cmd.decel_stop) decel_seen <= 1'b1;
  end
  // ----
  // tasks
  // ----
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // apb cycle; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // a switch needs a fresh 0->1 of the request bit
  task automatic req(input logic [31:0] c);
    xfer(1'b1, OFF_CTRL, c);
    xfer(1'b1, OFF_CTRL, c | 32'h4);
    repeat (3) @(posedge pclk);
  endtask : req
  task automatic until_ctq(input logic v);
    for (int i = 0; i < 40 && amp_cmd.ctq_mode !== v; i++) @(posedge pclk);
  endtask : until_ctq
  task automatic final_report;
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // ----
  // clock, watchdog, sequence
  // ----
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // the full sequence needs a few hundred clocks
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report;
  end
  initial begin
    {presetn, psel, penable, pwrite, slow, busy} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    xfer(1'b0, 8'h40, 32'h0);
    chk({perr, q}, 33'h1_0000_0000);
    xfer(1'b1, OFF_SPD_CMD, 32'h2000);
    req(32'h1);
    xfer(1'b1, OFF_ACC_TIME, 32'h1);
    chk($signed(amp_cmd.speed) < 32'sh400, 1);
    repeat (100) @(posedge pclk);
    xfer(1'b0, OFF_CMD_SPEED, 32'h0);
    chk(q, 32'h1000);
    chk(amp_cmd.speed, 32'h1000);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk(q[31:16], ERR_SPD_LIM);
    xfer(1'b0, OFF_FEED_POS, 32'h0);
    p1 = q;
    repeat (8) @(posedge pclk);
    xfer(1'b0, OFF_FEED_POS, 32'h0);
    chk(q != p1, 1);
    xfer(1'b0, OFF_REAL_POS, 32'h0);
    chk(q != 32'h0, 1);
    xfer(1'b1, OFF_CTRL, 32'h201);
    repeat (12) @(posedge pclk);
    chk(amp_cmd.speed, 32'h1000);
    xfer(1'b1, OFF_TQ_LIM_REQ, 32'h100);
    xfer(1'b1, OFF_CTRL, 32'h401);
    repeat (2) @(posedge pclk);
    chk(amp_cmd.torque_limit, 32'h100);
    // back inside the limit so 315 stops; the speed now ramps down
    xfer(1'b1, OFF_SPD_CMD, 32'h0C00);
    xfer(1'b1, OFF_TQ_LIM_REQ, 32'h200);
    xfer(1'b1, OFF_CTRL, 32'h401);
    xfer(1'b0, OFF_TQ_LIM, 32'h0);
    chk(q, 32'h100);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk(q[31:16], ERR_TQ_LIM);
    xfer(1'b1, OFF_TQ_CMD, 32'h55);
    slow <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      req(32'h0A | (k << 6) | ((k & 1) << 5));
      until_ctq(1'b1);
      chk(init_spd, (k == 0) ? 32'h0C00 : 32'h0BF0);
      chk(init_tq, (k == 1) ? 32'h3 : 32'h55);
      chk({st3[14], asa, psd, pd}, 4'hC);
      req(32'h9);
      until_ctq(1'b0);
      chk(amp_cmd.torque, 32'h0);
    end
    req(32'h0A);
    req(32'h08);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk({q[31:16], q[1:0]}, {ERR_MODE, 2'h2});
    req(32'h9);
    xfer(1'b1, OFF_STROKE_HI, 32'h0);
    xfer(1'b1, OFF_CTRL, 32'h101);
    repeat (12) @(posedge pclk);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk({q[31:16], q[1:0], amp_cmd.speed}, {ERR_STROKE, 2'h0, 32'h0});
    slow <= 1'b0;
    xfer(1'b1, OFF_SPD_CMD, 32'h100);
    req(32'h0A);
    req(32'h09);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk({q[31:16], q[1:0]}, {ERR_MODE, 2'h2});
    req(32'h08);
    chk(amp_cmd.ctq_mode, 1'b1);
    xfer(1'b1, OFF_SPD_CMD, 32'h0);
    repeat (12) @(posedge pclk);
    req(32'h08);
    until_ctq(1'b0);
    chk(amp_cmd.ctq_mode, 1'b0);
    req(32'h02);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk({q[31:16], q[1:0]}, {ERR_AMP, 2'h0});
    req(32'h01);
    req(32'h02);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk({q[31:16], q[1:0], stop_seen}, {ERR_AMP, 2'h0, 1'b1});
    busy <= 1'b1;
    req(32'h02);
    chk(decel_seen, 1'b1);
    final_report;
  end
endmodule : servo_axis_mode_switch_speed_ctrl_bench
